// ===== sio_top.sv
// serial i/o unit: shift port, card reader input and spi-style port
`timescale 1ns/1ps
module sio_top #(
  parameter int unsigned MAX_CHARS  = 40,
  parameter int unsigned BS_AET_1K  =
    sio_pkg::cyc_dn(sio_pkg::BS_AET_1K_NS),
  parameter int unsigned BS_HOLD_1K =
    sio_pkg::cyc_dn(sio_pkg::BS_HOLD_1K_NS),
  parameter int unsigned SM_HIGH_1K =
    sio_pkg::cyc_dn(sio_pkg::SM_HIGH_1K_NS)
) (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic                  start,
  input  wire sio_pkg::sio_mode_type mode,
  input  wire logic [1:0]            rate,
  input  wire logic                  shift_out,
  input  wire logic                  edge_fall,
  input  wire logic [7:0]            bit_count,
  input  wire logic [15:0]           tx_data,
  input  wire logic [7:0]            cs_mask,
  input  wire logic                  abort_en,
  input  wire logic [2:0]            abort_sel,
  input  wire logic                  rx_ready,
  output logic      [15:0]           rx_data,
  output logic                       rx_valid,
  output logic                       busy,
  output logic                       done,
  output logic                       fault,
  output logic                       check_fail,
  output logic                       tx_taken,
  input  wire logic                  port_pin_eight_in,
  output logic                       port_pin_eight_out,
  output logic                       port_pin_eight_oe_n,
  input  wire logic                  port_pin_nine_in,
  output logic                       port_pin_nine_out,
  output logic                       port_pin_nine_oe_n,
  input  wire logic                  port_pin_ten_in,
  input  wire logic [7:0]            low_port_pins_in,
  output logic      [7:0]            low_port_pins_out,
  output logic      [7:0]            low_port_pins_oe_n
);

  if (MAX_CHARS < 1 || MAX_CHARS > sio_pkg::MC_MAX_CHARS) begin
    $error("MAX_CHARS out of range");
  end
  if (BS_AET_1K > 65535 || BS_HOLD_1K >= BS_AET_1K ||
      SM_HIGH_1K > 65535 || BS_HOLD_1K < 1) begin
    $error("slow rate counts do not fit the timer");
  end

  sio_pkg::sio_state_type state;
  logic [10:0] in1;
  logic [10:0] in2;
  logic        prev8;
  logic [15:0] tmr;
  logic [15:0] lim;
  logic [7:0]  bits_left;
  logic [5:0]  chars;
  logic [5:0]  char_lim;
  logic [1:0]  rate_q;
  logic        edge_q;
  logic        dir_out;
  logic        abort_flag;
  logic [15:0] sh_rx;
  logic [15:0] sh_tx;
  logic [4:0]  sub;
  logic [15:0] hold;
  logic        pend;
  logic [4:0]  ch;
  logic [2:0]  cbit;
  logic        mc_sync;
  logic [3:0]  longitudinal_check;
  logic [15:0] q2;
  logic        q2_valid;

  logic        go;
  logic        tmr_end;
  logic        stall;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        abort_pin;
  logic        bs_sample;
  logic        bs_next;
  logic        spi_rise;
  logic        spi_fall;
  logic        last_bit;
  logic        rx_bit;
  logic [15:0] rx_word;
  logic        mc_bit;
  logic [4:0]  mc_char;
  logic        mc_done;
  logic        mc_last;
  logic        fifo_take;
  logic        fifo_pop;

  function automatic logic [15:0] bs_aet(input logic [1:0] r);
    case (r)
      sio_pkg::RATE_FAST: return sio_pkg::BS_AET_15K_CYC;
      sio_pkg::RATE_MID:  return sio_pkg::BS_AET_10K_CYC;
      default:            return BS_AET_1K[15:0];
    endcase
  endfunction

  function automatic logic [15:0] bs_hold(input logic [1:0] r);
    case (r)
      sio_pkg::RATE_FAST: return sio_pkg::BS_HOLD_15K_CYC;
      sio_pkg::RATE_MID:  return sio_pkg::BS_HOLD_10K_CYC;
      default:            return BS_HOLD_1K[15:0];
    endcase
  endfunction

  function automatic logic [15:0] sm_high(input logic [1:0] r);
    case (r)
      sio_pkg::RATE_FAST: return sio_pkg::SM_HIGH_20K_CYC;
      sio_pkg::RATE_MID:  return sio_pkg::SM_HIGH_10K_CYC;
      default:            return SM_HIGH_1K[15:0];
    endcase
  endfunction

  // two-stage synchroniser for every pin read by the block
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      in1   <= 11'h000;
      in2   <= 11'h000;
      prev8 <= 1'b0;
    end else begin
      in1   <= {port_pin_ten_in, port_pin_nine_in, port_pin_eight_in,
                low_port_pins_in};
      in2   <= in1;
      prev8 <= in2[8];
    end
  end

  // phase length for the timed states
  always_comb begin
    unique case (state)
      sio_pkg::ST_BS_SETUP: lim = sio_pkg::BS_SETUP_CYC;
      sio_pkg::ST_BS_ACT:   lim = bs_aet(rate_q);
      sio_pkg::ST_BS_GAP:   lim = sio_pkg::BS_GAP_CYC;
      sio_pkg::ST_SM_LEAD:  lim = sio_pkg::SM_LEAD_CYC;
      sio_pkg::ST_SM_LOW:   lim = sio_pkg::SM_LOW_CYC;
      sio_pkg::ST_SM_HIGH:  lim = sm_high(rate_q);
      sio_pkg::ST_SM_TAIL:  lim = sio_pkg::SM_TAIL_CYC;
      default:              lim = 16'h0001;
    endcase
  end

  assign go        = (state == sio_pkg::ST_IDLE) && start;
  assign tmr_end   = (tmr == lim - 16'h0001);
  assign stall     = (state == sio_pkg::ST_SM_LOW) && pend;
  assign sclk_rise = in2[8] && !prev8;
  assign sclk_fall = !in2[8] && prev8;
  assign abort_pin = abort_en && in2[abort_sel];
  assign last_bit  = (bits_left == 8'h01);
  assign bs_sample = (state == sio_pkg::ST_BS_ACT) && !dir_out &&
                     (tmr == bs_hold(rate_q) - 16'h0001);
  assign bs_next   = (state == sio_pkg::ST_BS_GAP) && tmr_end;
  assign spi_rise  = ((state == sio_pkg::ST_SM_LEAD) && tmr_end) ||
                     ((state == sio_pkg::ST_SM_LOW) && tmr_end && !pend) ||
                     ((state == sio_pkg::ST_SS) && sclk_rise);
  assign spi_fall  = ((state == sio_pkg::ST_SM_HIGH) && tmr_end &&
                      bits_left != 8'h00) ||
                     ((state == sio_pkg::ST_SS) && sclk_fall);
  assign rx_bit    = (state == sio_pkg::ST_BS_ACT) ? in2[9] : in2[10];
  assign rx_word   = {sh_rx[14:0], rx_bit};
  assign mc_bit    = (state == sio_pkg::ST_MC) && sclk_fall &&
                     (mc_sync || in2[9]);
  assign mc_char   = {in2[9], ch[4:1]};
  assign mc_done   = mc_bit && (cbit == sio_pkg::MC_LAST_BIT);
  assign mc_last   = (chars == char_lim - 6'h01);
  assign fifo_take = pend && !q2_valid;
  assign fifo_pop  = rx_valid && rx_ready;

  // sequencing, timing, clock pin, selects and outcome
  always_ff @(posedge clk) begin
    done <= 1'b0;
    fault <= 1'b0;
    if (sys_rst) begin
      state               <= sio_pkg::ST_IDLE;
      tmr                 <= 16'h0000;
      bits_left           <= 8'h00;
      chars               <= 6'h00;
      char_lim            <= 6'h00;
      rate_q              <= 2'h0;
      edge_q              <= 1'b0;
      dir_out             <= 1'b0;
      abort_flag          <= 1'b0;
      busy                <= 1'b0;
      port_pin_eight_out  <= 1'b0;
      port_pin_eight_oe_n <= 1'b1;
      port_pin_nine_oe_n  <= 1'b1;
      low_port_pins_out   <= sio_pkg::CS_IDLE;
      low_port_pins_oe_n  <= sio_pkg::CS_IDLE;
    end else begin
      if (tmr_end && !stall) begin
        tmr <= 16'h0000;
      end else if (!tmr_end) begin
        tmr <= tmr + 16'h0001;
      end
      if (spi_rise || (state == sio_pkg::ST_BS_ACT && tmr_end)) begin
        bits_left <= bits_left - 8'h01;
      end
      unique case (state)
        sio_pkg::ST_IDLE: begin
          low_port_pins_out  <= sio_pkg::CS_IDLE;
          low_port_pins_oe_n <= ~cs_mask;
          if (start) begin
            busy       <= 1'b1;
            tmr        <= 16'h0000;
            rate_q     <= rate;
            edge_q     <= edge_fall;
            dir_out    <= shift_out;
            abort_flag <= 1'b0;
            chars      <= 6'h00;
            bits_left  <= bit_count;
            char_lim   <= (bit_count > 8'(MAX_CHARS)) ?
                          6'(MAX_CHARS) : bit_count[5:0];
            if (bit_count == 8'h00) begin
              state <= sio_pkg::ST_END;
            end else begin
              unique case (mode)
                sio_pkg::SIO_BITSHIFT: begin
                  state               <= sio_pkg::ST_BS_SETUP;
                  port_pin_eight_out  <= edge_fall;
                  port_pin_eight_oe_n <= 1'b0;
                  port_pin_nine_oe_n  <= ~shift_out;
                  if (bit_count > 8'(sio_pkg::BS_MAX_BITS)) begin
                    bits_left <= 8'(sio_pkg::BS_MAX_BITS);
                  end
                end
                sio_pkg::SIO_MAGCARD: begin
                  state <= sio_pkg::ST_MC;
                end
                sio_pkg::SIO_SPI_MASTER: begin
                  state               <= sio_pkg::ST_SM_LEAD;
                  port_pin_eight_out  <= 1'b0;
                  port_pin_eight_oe_n <= 1'b0;
                  port_pin_nine_oe_n  <= 1'b0;
                  low_port_pins_out   <= ~cs_mask;
                end
                sio_pkg::SIO_SPI_SLAVE: begin
                  state              <= sio_pkg::ST_SS;
                  port_pin_nine_oe_n <= 1'b0;
                end
              endcase
            end
          end
        end
        sio_pkg::ST_BS_SETUP: begin
          if (tmr_end) begin
            port_pin_eight_out <= ~edge_q;
            state              <= sio_pkg::ST_BS_ACT;
          end
        end
        sio_pkg::ST_BS_ACT: begin
          if (tmr_end) begin
            port_pin_eight_out <= edge_q;
            state <= last_bit ? sio_pkg::ST_END : sio_pkg::ST_BS_GAP;
          end
        end
        sio_pkg::ST_BS_GAP: begin
          if (tmr_end) begin
            state <= sio_pkg::ST_BS_SETUP;
          end
        end
        sio_pkg::ST_MC: begin
          if (abort_pin) begin
            abort_flag <= 1'b1;
            state      <= sio_pkg::ST_END;
          end else if (mc_done) begin
            chars <= chars + 6'h01;
            if (mc_last) begin
              state <= sio_pkg::ST_END;
            end
          end
        end
        sio_pkg::ST_SM_LEAD, sio_pkg::ST_SM_LOW: begin
          if (spi_rise) begin
            port_pin_eight_out <= 1'b1;
            state              <= sio_pkg::ST_SM_HIGH;
          end
        end
        sio_pkg::ST_SM_HIGH: begin
          if (tmr_end) begin
            port_pin_eight_out <= 1'b0;
            state <= (bits_left == 8'h00) ? sio_pkg::ST_SM_TAIL
                                          : sio_pkg::ST_SM_LOW;
          end
        end
        sio_pkg::ST_SM_TAIL: begin
          if (tmr_end) begin
            low_port_pins_out <= sio_pkg::CS_IDLE;
            state             <= sio_pkg::ST_END;
          end
        end
        sio_pkg::ST_SS: begin
          if (abort_pin) begin
            abort_flag <= 1'b1;
            state      <= sio_pkg::ST_END;
          end else if (spi_rise && last_bit) begin
            state <= sio_pkg::ST_END;
          end
        end
        sio_pkg::ST_END: begin
          port_pin_eight_oe_n <= 1'b1;
          port_pin_nine_oe_n  <= 1'b1;
          if (!pend) begin
            busy  <= 1'b0;
            done  <= !(abort_flag || check_fail);
            fault <= abort_flag || check_fail;
            state <= sio_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // data shifting, card character checks and the word hand-off
  always_ff @(posedge clk) begin
    tx_taken <= 1'b0;
    if (sys_rst) begin
      sh_rx             <= sio_pkg::WORD_RST;
      sh_tx             <= sio_pkg::WORD_RST;
      hold              <= sio_pkg::WORD_RST;
      sub               <= 5'h00;
      pend              <= 1'b0;
      ch                <= 5'h00;
      cbit              <= 3'h0;
      mc_sync           <= 1'b0;
      longitudinal_check               <= 4'h0;
      check_fail        <= 1'b0;
      port_pin_nine_out <= 1'b0;
    end else begin
      if (fifo_take) begin
        pend <= 1'b0;
      end
      if (go) begin
        sh_rx             <= sio_pkg::WORD_RST;
        sh_tx             <= tx_data;
        port_pin_nine_out <= tx_data[15];
        sub               <= 5'h00;
        cbit              <= 3'h0;
        mc_sync           <= 1'b0;
        longitudinal_check               <= 4'h0;
        check_fail        <= 1'b0;
      end
      if (bs_sample || spi_rise) begin
        sh_rx <= rx_word;
        sub   <= (sub == sio_pkg::WORD_LAST) ? 5'h00 : sub + 5'h01;
        if (sub == sio_pkg::WORD_LAST || last_bit) begin
          hold <= rx_word;
          pend <= 1'b1;
        end
      end
      if (bs_next || spi_fall) begin
        if (sub == 5'h00 && !bs_next) begin
          sh_tx             <= tx_data;
          port_pin_nine_out <= tx_data[15];
          tx_taken          <= 1'b1;
        end else begin
          sh_tx             <= {sh_tx[14:0], 1'b0};
          port_pin_nine_out <= sh_tx[14];
        end
      end
      if (mc_bit) begin
        mc_sync <= 1'b1;
        ch      <= mc_char;
        cbit    <= mc_done ? 3'h0 : cbit + 3'h1;
        if (mc_done) begin
          longitudinal_check  <= longitudinal_check ^ mc_char[3:0];
          hold <= {11'h000, mc_char};
          pend <= 1'b1;
          if (!(^mc_char)) begin
            check_fail <= 1'b1;
          end
          if (mc_last && (longitudinal_check ^ mc_char[3:0]) != 4'h0) begin
            check_fail <= 1'b1;
          end
        end
      end
    end
  end

  // two-entry buffer between the shifter and the receiver
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_data  <= sio_pkg::WORD_RST;
      rx_valid <= 1'b0;
      q2       <= sio_pkg::WORD_RST;
      q2_valid <= 1'b0;
    end else if (fifo_pop) begin
      if (q2_valid) begin
        rx_data  <= q2;
        q2       <= hold;
        q2_valid <= fifo_take;
      end else begin
        rx_data  <= hold;
        rx_valid <= fifo_take;
      end
    end else if (fifo_take) begin
      if (!rx_valid) begin
        rx_data  <= hold;
        rx_valid <= 1'b1;
      end else begin
        q2       <= hold;
        q2_valid <= 1'b1;
      end
    end
  end

endmodule

// ===== sio_pkg.sv
// shared constants and types for the serial i/o unit
//
// What this block does
// - shift port drives clock on pin eight, up to 16 data bits on nine
// - shift port rates 1, 10 or 15 kbps, all counted in clock cycles
// - shift port active clock edge selectable rising or falling
// - shift input samples data a rate-dependent delay after active edge
// - shift output data stable a fixed time before each active edge
// - card data captured at strobe falling edge, least significant bit first
// - selectable low pin pulse aborts a card read
// - one card read takes at most 40 characters
// - card character parity and longitudinal check verified, failure reported
// - spi port full duplex as master or slave, up to 255 bits
// - spi master clock pin eight, data out pin nine, data in pin ten
// - one bit in on each rising and one bit out on each falling serial clock except the falling edge after the last bit
// - master selects lead first edge by 91.2 us, trail by 81.6 us
// - spi master rates 1, 10 or 20 kbps, counted in clock cycles
// - master data stable 5.4 us before rise, clock low 33 us
// - slave transfer ends early on a one at the abort pin
package sio_pkg;

  localparam int CLK_NS = 50;

  function automatic int cyc_up(input int ns);
    return (ns + CLK_NS - 1) / CLK_NS;
  endfunction

  function automatic int cyc_dn(input int ns);
    return (ns < CLK_NS) ? 1 : ns / CLK_NS;
  endfunction

  localparam int BS_SETUP_NS    = 10800;
  localparam int BS_TAE_NS      = 34800;
  localparam int BS_AET_15K_NS  = 10200;
  localparam int BS_AET_10K_NS  = 42000;
  localparam int BS_AET_1K_NS   = 939500;
  localparam int BS_HOLD_15K_NS = 9000;
  localparam int BS_HOLD_10K_NS = 40800;
  localparam int BS_HOLD_1K_NS  = 938200;
  localparam int SM_SETUP_NS    = 5400;
  localparam int SM_LOW_NS      = 33000;
  localparam int SM_HIGH_20K_NS = 25800;
  localparam int SM_HIGH_10K_NS = 67800;
  localparam int SM_HIGH_1K_NS  = 975000;
  localparam int SM_LEAD_NS     = 91200;
  localparam int SM_TAIL_NS     = 81600;

  localparam logic [15:0] BS_SETUP_CYC    = 16'(cyc_up(BS_SETUP_NS));
  localparam logic [15:0] BS_GAP_CYC      =
    16'(cyc_dn(BS_TAE_NS - BS_SETUP_NS));
  localparam logic [15:0] BS_AET_15K_CYC  = 16'(cyc_dn(BS_AET_15K_NS));
  localparam logic [15:0] BS_AET_10K_CYC  = 16'(cyc_dn(BS_AET_10K_NS));
  localparam logic [15:0] BS_HOLD_15K_CYC = 16'(cyc_dn(BS_HOLD_15K_NS));
  localparam logic [15:0] BS_HOLD_10K_CYC = 16'(cyc_dn(BS_HOLD_10K_NS));
  localparam logic [15:0] SM_LOW_CYC      = 16'(cyc_dn(SM_LOW_NS));
  localparam logic [15:0] SM_HIGH_20K_CYC = 16'(cyc_dn(SM_HIGH_20K_NS));
  localparam logic [15:0] SM_HIGH_10K_CYC = 16'(cyc_dn(SM_HIGH_10K_NS));
  localparam logic [15:0] SM_LEAD_CYC     = 16'(cyc_up(SM_LEAD_NS));
  localparam logic [15:0] SM_TAIL_CYC     = 16'(cyc_up(SM_TAIL_NS));

  localparam logic [1:0]  RATE_FAST    = 2'h2;
  localparam logic [1:0]  RATE_MID     = 2'h1;
  localparam int          BS_MAX_BITS  = 16;
  localparam int          MC_MAX_CHARS = 40;
  localparam logic [2:0]  MC_LAST_BIT  = 3'h4;
  localparam logic [4:0]  WORD_LAST    = 5'hf;
  localparam logic [7:0]  CS_IDLE      = 8'hff;
  localparam logic [15:0] WORD_RST     = 16'h0000;

  typedef enum logic [1:0] {
    SIO_BITSHIFT,
    SIO_MAGCARD,
    SIO_SPI_MASTER,
    SIO_SPI_SLAVE
  } sio_mode_type;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_BS_SETUP,
    ST_BS_ACT,
    ST_BS_GAP,
    ST_MC,
    ST_SM_LEAD,
    ST_SM_LOW,
    ST_SM_HIGH,
    ST_SM_TAIL,
    ST_SS,
    ST_END
  } sio_state_type;

endpackage

// ===== sio_top_props.sv
// port checker for the serial i/o unit, bound to sio_top
`timescale 1ns/1ps
module sio_chk (
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire logic                  start,
  input wire sio_pkg::sio_mode_type mode,
  input wire logic                  shift_out,
  input wire logic                  edge_fall,
  input wire logic [7:0]            bit_count,
  input wire logic                  abort_en,
  input wire logic [2:0]            abort_sel,
  input wire logic                  busy,
  input wire logic                  done,
  input wire logic                  fault,
  input wire logic                  tx_taken,
  input wire logic                  port_pin_eight_out,
  input wire logic                  port_pin_eight_oe_n,
  input wire logic                  port_pin_nine_out,
  input wire logic [7:0]            low_port_pins_in,
  input wire logic [7:0]            low_port_pins_out,
  input wire logic [7:0]            low_port_pins_oe_n
);
  localparam logic [15:0] MSU = 16'(sio_pkg::cyc_up(sio_pkg::SM_SETUP_NS));
  logic        p8, p9, pcs;
  logic [15:0] c8, c9, ccs;
  wire         cs_all = &(low_port_pins_out | low_port_pins_oe_n);
  wire         sm     = mode == sio_pkg::SIO_SPI_MASTER;

  // cycles each pin has held its present level, saturating
  function automatic logic [15:0] age(input logic chg, input logic [15:0] c);
    return chg ? 16'h0001 : c + {15'h0, ~&c};
  endfunction

  always_ff @(posedge clk) begin
    p8  <= port_pin_eight_out;
    p9  <= port_pin_nine_out;
    pcs <= cs_all;
    if (sys_rst) begin
      c8  <= 16'h0000;
      c9  <= 16'h0000;
      ccs <= 16'h0000;
    end else begin
      c8  <= age(port_pin_eight_out != p8, c8);
      c9  <= age(port_pin_nine_out != p9, c9);
      ccs <= age(cs_all != pcs, ccs);
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_mrise;
    sm && $rose(port_pin_eight_out);
  endsequence
  sequence s_brise;
    mode == sio_pkg::SIO_BITSHIFT && shift_out && !edge_fall &&
      $rose(port_pin_eight_out);
  endsequence
  // mode bit zero marks the card and slave modes
  sequence s_abort;
    busy && abort_en && mode[0] && $rose(low_port_pins_in[abort_sel]);
  endsequence

  cs_idle_a: assert property (!busy |-> cs_all)
    else $error("chip select active while idle");
  pins_idle_a: assert property (!busy |-> port_pin_eight_oe_n)
    else $error("clock pin driven while idle");
  done_pulse_a: assert property (done |=> !done)
    else $error("done longer than one cycle");
  end_excl_a: assert property (done |-> !fault)
    else $error("done and fault together");
  start_busy_a: assert property (
    start && !busy && bit_count != 8'h00 |=> busy)
    else $error("start not taken");
  lead_time_a: assert property (
    s_mrise |-> !cs_all && ccs >= sio_pkg::SM_LEAD_CYC - 16'h0002)
    else $error("select lead too short");
  tail_time_a: assert property (
    sm && $rose(cs_all) |-> c8 >= sio_pkg::SM_TAIL_CYC - 16'h0002)
    else $error("select tail too short");
  low_phase_a: assert property (
    s_mrise |-> c8 >= sio_pkg::SM_LOW_CYC - 16'h0002)
    else $error("clock low phase too short");
  m_setup_a: assert property (s_mrise |-> c9 >= MSU - 16'h0002)
    else $error("master data setup too short");
  b_setup_a: assert property (
    s_brise |-> c9 >= sio_pkg::BS_SETUP_CYC - 16'h0002)
    else $error("shift data setup too short");
  abort_end_a: assert property (s_abort |-> ##[1:8] fault)
    else $error("abort did not end transfer");
  taken_spi_a: assert property (tx_taken |-> busy && mode[1])
    else $error("transmit reload outside spi transfer");
endmodule

bind sio_top sio_chk u_chk (
  .clk, .sys_rst, .start, .mode, .shift_out, .edge_fall, .bit_count,
  .abort_en, .abort_sel, .busy, .done, .fault, .tx_taken, .port_pin_eight_out,
  .port_pin_eight_oe_n, .port_pin_nine_out, .low_port_pins_in,
  .low_port_pins_out, .low_port_pins_oe_n
);

// ===== sio_far.sv
// far-side model: spi peripheral, shift register and card reader
`timescale 1ns/1ps
module sio_far (
  input  wire logic        sck,
  input  wire logic        sdi,
  input  wire logic        sel_n,
  input  wire logic        load,
  input  wire logic [15:0] reply,
  output logic             dout,
  output logic             strobe,
  output logic             cdata,
  output logic [15:0]      got
);
  logic [15:0] rep = 16'h0000;

  initial begin
    strobe = 1'b1;
    cdata = 1'b0;
  end

  always @(posedge load) begin
    got = 16'h0000;
    rep = reply;
  end
  always @(posedge sck) got = {got[14:0], sdi};
  always @(negedge sck) rep = {rep[14:0], ~rep[15]};
  // unselected output shows the inverse of the current bit
  assign dout = sel_n ? ~rep[15] : rep[15];

  // card bits sent lsb first, data held across the falling strobe
  task automatic card(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      cdata = bits[i];
      #200 strobe = 1'b0;
      #200 strobe = 1'b1;
    end
    cdata = ~cdata;
  endtask
endmodule

// ===== test_serial_io_objects.sv
// self-checking bench for the serial i/o unit
`timescale 1ns/1ps
module test_serial_io_objects;
  logic                  clk = 1'b0;
  logic                  sys_rst, start, shift_out, edge_fall, abort_en;
  logic                  rx_ready, load, saw_done, saw_fault;
  sio_pkg::sio_mode_type mode;
  logic [1:0]            rate;
  logic [2:0]            abort_sel;
  logic [7:0]            bit_count, cs_mask, abort_drv, low_pins;
  logic [15:0]           tx_data, reply, rx_data, got;
  logic                  rx_valid, busy, done, fault, check_fail, tx_taken;
  logic                  port_pin_eight_out, port_pin_eight_oe_n;
  logic                  port_pin_nine_out, port_pin_nine_oe_n;
  logic [7:0]            low_port_pins_out, low_port_pins_oe_n;
  logic                  pin8, pin9, dout, strobe, cdata;
  int                    n_mismatch = 0;
  int                    checks = 0;
  int                    cyc = 0;

  // released clock pin: strobe in card and slave modes, pulled low otherwise
  assign pin8 = !port_pin_eight_oe_n ? port_pin_eight_out :
                mode[0] ? strobe : 1'b0;
  assign pin9 = !port_pin_nine_oe_n ? port_pin_nine_out :
                (mode == sio_pkg::SIO_MAGCARD) ? cdata : dout;
  assign low_pins = (low_port_pins_out & ~low_port_pins_oe_n) |
                    (abort_drv & low_port_pins_oe_n);
  always #25 clk = ~clk;

  sio_top #(.BS_AET_1K(40), .BS_HOLD_1K(30), .SM_HIGH_1K(40)) DUT (
    .clk, .sys_rst, .start, .mode, .rate, .shift_out, .edge_fall,
    .bit_count, .tx_data, .cs_mask, .abort_en, .abort_sel, .rx_ready,
    .rx_data, .rx_valid, .busy, .done, .fault, .check_fail, .tx_taken,
    .port_pin_eight_in(pin8), .port_pin_eight_out, .port_pin_eight_oe_n,
    .port_pin_nine_in(pin9), .port_pin_nine_out, .port_pin_nine_oe_n,
    .port_pin_ten_in(dout), .low_port_pins_in(low_pins),
    .low_port_pins_out, .low_port_pins_oe_n);
  sio_far far (.sck(pin8), .sdi(pin9), .load, .reply, .dout, .strobe,
    .sel_n(mode == sio_pkg::SIO_SPI_MASTER && low_pins[0]), .cdata, .got);

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (start) begin
      saw_done <= 1'b0;
      saw_fault <= 1'b0;
    end
    if (done) saw_done <= 1'b1;
    if (fault) saw_fault <= 1'b1;
    if (cyc == 90000) begin
      n_mismatch++;
      $display("timeout after %0d cycles", cyc);
      close_out;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, act);
    checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, act);
    end
  endtask

  task automatic run(input sio_pkg::sio_mode_type m, input logic [7:0] n,
                     input logic [15:0] tx);
    mode = m;
    bit_count = n;
    tx_data = tx;
    load = 1'b1;
    start = 1'b1;
    tick(1);
    start = 1'b0;
    load = 1'b0;
  endtask

  task automatic pop(input logic [15:0] exp);
    int k = 0;
    while (rx_valid !== 1'b1 && k < 40000) begin
      tick(1);
      k++;
    end
    chk("rx valid", 16'h0001, {15'h0, rx_valid});
    chk("rx word", exp, rx_data);
    rx_ready = 1'b1;
    tick(1);
    rx_ready = 1'b0;
  endtask

  task automatic wait_idle(input logic ok);
    int k = 0;
    while (busy !== 1'b0 && k < 40000) begin
      tick(1);
      k++;
    end
    tick(1);
    chk("done seen", {15'h0, ok}, {15'h0, saw_done});
    chk("fault seen", {15'h0, ~ok}, {15'h0, saw_fault});
  endtask

  initial begin
    sys_rst = 1'b1;
    start = 1'b0;
    load = 1'b0;
    rx_ready = 1'b0;
    mode = sio_pkg::SIO_BITSHIFT;
    rate = 2'h2;
    shift_out = 1'b1;
    edge_fall = 1'b0;
    bit_count = 8'h00;
    tx_data = 16'h0000;
    reply = 16'h3c5a;
    cs_mask = 8'h01;
    abort_en = 1'b0;
    abort_sel = 3'h0;
    abort_drv = 8'h00;
    tick(20);
    sys_rst = 1'b0;
    run(sio_pkg::SIO_SPI_MASTER, 8'h10, 16'ha5c3);
    pop(16'h3c5a);
    wait_idle(1'b1);
    chk("spi sent", 16'ha5c3, got);
    $display("test spi master finished");
    rx_ready = 1'b1;
    run(sio_pkg::SIO_BITSHIFT, 8'h10, 16'h96e1);
    wait_idle(1'b1);
    chk("shift sent", 16'h96e1, got);
    rx_ready = 1'b0;
    shift_out = 1'b0;
    rate = 2'h1;
    reply = 16'hc3a5;
    run(sio_pkg::SIO_BITSHIFT, 8'h08, 16'h0000);
    pop(16'h00c3);
    wait_idle(1'b1);
    $display("test shift port finished");
    run(sio_pkg::SIO_MAGCARD, 8'h02, 16'h0000);
    far.card({2'b00, 5'h15, 5'h15, 4'h0}, 14);
    tick(20);
    chk("buffer full", 16'h0001, {15'h0, rx_valid});
    pop(16'h0015);
    pop(16'h0015);
    wait_idle(1'b1);
    chk("check flag", 16'h0000, {15'h0, check_fail});
    run(sio_pkg::SIO_MAGCARD, 8'h02, 16'h0000);
    far.card({2'b00, 5'h15, 5'h05, 4'h0}, 14);
    pop(16'h0005);
    pop(16'h0015);
    wait_idle(1'b0);
    chk("check flag", 16'h0001, {15'h0, check_fail});
    $display("test card reader finished");
    run(sio_pkg::SIO_SPI_SLAVE, 8'h10, 16'h5a3c);
    far.card(16'h0000, 16);
    pop(16'h874a);
    wait_idle(1'b1);
    chk("slave sent", 16'h5a3c, got);
    $display("test spi slave finished");
    abort_en = 1'b1;
    cs_mask = 8'h00;
    for (int i = 0; i < 2; i++) begin
      abort_sel = i ? 3'h5 : 3'h3;
      run(i ? sio_pkg::SIO_MAGCARD : sio_pkg::SIO_SPI_SLAVE, 8'h08, 16'h0);
      tick(10);
      abort_drv = 8'h01 << abort_sel;
      wait_idle(1'b0);
      abort_drv = 8'h00;
      tick(2);
    end
    $display("test abort finished");
    close_out;
  end
endmodule
